// file: hdl/video_forward_clock_config.v
// Behaviour
// - low period bits 7:0, read/write, reset zero
// - high byte gives bits 15:8, combined
// - separate mode: generator held off, sync_out low
// - frame limit high:low, reset 0x0004
// - unpacketized mode inserts frame number in packets
// - count from one, wrap after limit
// - oscillator select bit picks reference, reset zero
// - two-bit speed field, reset 10
// - port n forward off at bit 4+n
// - port n output select at bit n
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "video_forward_clock_config_regs.vh"

module video_forward_clock_config (
    input  wire        clk,
    input  wire        reset_n,
    input  wire [9:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [9:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        raw_mode,
    input  wire        frame_start,
    input  wire        frame_end,
    output reg  [15:0] frame_number,
    output reg         sync_out,
    output wire        internal_oscillator_select,
    output wire        ref_clock_100m,
    output wire [1:0]  tx_speed,
    output wire [3:0]  port_forward_off,
    output wire [3:0]  port_output_select
);

////////////////////////////////////////////////////////////////////////////////
reg  [7:0]  sync_low_period_low_byte;
reg  [7:0]  sync_low_period_high_byte;
reg  [7:0]  sync_control;
reg  [7:0]  frame_count_limit_high;
reg  [7:0]  frame_count_limit_low;
reg  [7:0]  output_clock_control;
reg  [7:0]  port_forward_control;
reg         aw_held;
reg  [7:0]  aw_index;
reg         w_held;
reg  [7:0]  w_data;
reg         w_lane0;
wire        do_write;
reg  [7:0]  read_value;
reg         read_hit;
reg         write_hit;
wire        reg_write;
wire        port0_forward_off;
wire        port1_forward_off;
wire        port2_forward_off;
wire        port3_forward_off;
wire        port0_output_select;
wire        port1_output_select;
wire        port2_output_select;
wire        port3_output_select;

function [7:0] word_index;
    input [9:0] addr;
    begin
        word_index = addr[9:2];
    end
endfunction

function index_match;
    input [7:0] held;
    input [7:0] idx;
    begin
        index_match = (held == idx);
    end
endfunction

function hit_index;
    input [7:0] idx;
    begin
        hit_index = (idx == `IDX_SYNC_LOW_PERIOD_LOW_BYTE) ||
                    (idx == `IDX_SYNC_LOW_PERIOD_HIGH_BYTE) ||
                    (idx == `IDX_SYNC_CONTROL) ||
                    (idx == `IDX_FRAME_COUNT_LIMIT_HIGH) ||
                    (idx == `IDX_FRAME_COUNT_LIMIT_LOW) ||
                    (idx == `IDX_OUTPUT_CLOCK_CONTROL) ||
                    (idx == `IDX_PORT_FORWARD_CONTROL);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// write path: address and data taken in either order, one write at a time
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready  = !w_held && !s_axi_bvalid;
assign do_write      = aw_held && w_held;

// taking and completing never meet: ready is low while held
always @(posedge clk) begin
    if (!reset_n) begin
        aw_held  <= 1'b0;
        aw_index <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
        aw_held  <= 1'b1;
        aw_index <= word_index(s_axi_awaddr);
    end else if (do_write) begin
        aw_held <= 1'b0;
    end
end

always @(posedge clk) begin
    if (!reset_n) begin
        w_held  <= 1'b0;
        w_data  <= 8'h00;
        w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
        w_held <= 1'b0;
    end
end

always @(posedge clk) begin
    if (!reset_n) begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= `AXI_RESP_OKAY;
    end else if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= write_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
    end
end

always @* begin
    write_hit = hit_index(aw_index);
end

// only byte lane 0 carries register data; upper lanes are ignored
assign reg_write = do_write && w_lane0;

always @(posedge clk) begin
    if (!reset_n) begin
        sync_low_period_low_byte <= `RST_SYNC_LOW_PERIOD_LOW_BYTE;
    end else if (reg_write && index_match(aw_index, `IDX_SYNC_LOW_PERIOD_LOW_BYTE)) begin
        sync_low_period_low_byte <= w_data;
    end
end

always @(posedge clk) begin
    if (!reset_n) begin
        sync_low_period_high_byte <= `RST_SYNC_LOW_PERIOD_HIGH_BYTE;
    end else if (reg_write && index_match(aw_index, `IDX_SYNC_LOW_PERIOD_HIGH_BYTE)) begin
        sync_low_period_high_byte <= w_data;
    end
end

always @(posedge clk) begin
    if (!reset_n) begin
        sync_control <= `RST_SYNC_CONTROL;
    end else if (reg_write && index_match(aw_index, `IDX_SYNC_CONTROL)) begin
        sync_control <= w_data;
    end
end

always @(posedge clk) begin
    if (!reset_n) begin
        frame_count_limit_high <= `RST_FRAME_COUNT_LIMIT_HIGH;
    end else if (reg_write && index_match(aw_index, `IDX_FRAME_COUNT_LIMIT_HIGH)) begin
        frame_count_limit_high <= w_data;
    end
end

always @(posedge clk) begin
    if (!reset_n) begin
        frame_count_limit_low <= `RST_FRAME_COUNT_LIMIT_LOW;
    end else if (reg_write && index_match(aw_index, `IDX_FRAME_COUNT_LIMIT_LOW)) begin
        frame_count_limit_low <= w_data;
    end
end

// upper nibble reserved, reads zero
always @(posedge clk) begin
    if (!reset_n) begin
        output_clock_control <= `RST_OUTPUT_CLOCK_CONTROL;
    end else if (reg_write && index_match(aw_index, `IDX_OUTPUT_CLOCK_CONTROL)) begin
        output_clock_control <= w_data & `OCC_WRITE_MASK;
    end
end

always @(posedge clk) begin
    if (!reset_n) begin
        port_forward_control <= `RST_PORT_FORWARD_CONTROL;
    end else if (reg_write && index_match(aw_index, `IDX_PORT_FORWARD_CONTROL)) begin
        port_forward_control <= w_data;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read path
assign s_axi_arready = !s_axi_rvalid;

always @* begin
    read_hit = hit_index(word_index(s_axi_araddr));
    case (word_index(s_axi_araddr))
        `IDX_SYNC_LOW_PERIOD_LOW_BYTE: begin
            read_value = sync_low_period_low_byte;
        end
        `IDX_SYNC_LOW_PERIOD_HIGH_BYTE: begin
            read_value = sync_low_period_high_byte;
        end
        `IDX_SYNC_CONTROL: begin
            read_value = sync_control;
        end
        `IDX_FRAME_COUNT_LIMIT_HIGH: begin
            read_value = frame_count_limit_high;
        end
        `IDX_FRAME_COUNT_LIMIT_LOW: begin
            read_value = frame_count_limit_low;
        end
        `IDX_OUTPUT_CLOCK_CONTROL: begin
            read_value = output_clock_control;
        end
        `IDX_PORT_FORWARD_CONTROL: begin
            read_value = port_forward_control;
        end
        default: begin
            read_value = 8'h00;
        end
    endcase
end

always @(posedge clk) begin
    if (!reset_n) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h0000_0000;
        s_axi_rresp  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, read_value};
        s_axi_rresp  <= read_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// clock and forwarding controls, straight from the registers
assign internal_oscillator_select = output_clock_control[`OCC_OSC_SELECT_BIT];
// no lockout of 100 MHz with 400 Mbps: software must avoid it
assign ref_clock_100m = output_clock_control[`OCC_REF_MODE_BIT];
assign tx_speed = output_clock_control[`OCC_SPEED_MSB:`OCC_SPEED_LSB];
// two named bits per receive port: forward off and output select
assign port0_forward_off   = port_forward_control[`PFC_OFF_LSB + 0];
assign port1_forward_off   = port_forward_control[`PFC_OFF_LSB + 1];
assign port2_forward_off   = port_forward_control[`PFC_OFF_LSB + 2];
assign port3_forward_off   = port_forward_control[`PFC_OFF_LSB + 3];
assign port0_output_select = port_forward_control[`PFC_SELECT_LSB + 0];
assign port1_output_select = port_forward_control[`PFC_SELECT_LSB + 1];
assign port2_output_select = port_forward_control[`PFC_SELECT_LSB + 2];
assign port3_output_select = port_forward_control[`PFC_SELECT_LSB + 3];
assign port_forward_off   = {port3_forward_off, port2_forward_off,
                             port1_forward_off, port0_forward_off};
assign port_output_select = {port3_output_select, port2_output_select,
                             port1_output_select, port0_output_select};

////////////////////////////////////////////////////////////////////////////////
// frame number counter
wire [15:0] frame_limit = {frame_count_limit_high, frame_count_limit_low};
reg  [15:0] next_count;
reg  [15:0] count;
reg         in_frame;

always @* begin
    if (frame_limit == 16'h0000) begin
        next_count = 16'h0000;
    end else if (count >= frame_limit || count == 16'h0000) begin
        next_count = 16'h0001;
    end else begin
        next_count = count + 16'h0001;
    end
end

// number latched at frame start holds through frame end
always @(posedge clk) begin
    if (!reset_n) begin
        count        <= 16'h0000;
        frame_number <= 16'h0000;
        in_frame     <= 1'b0;
    end else if (raw_mode) begin
        if (frame_start && !in_frame) begin
            in_frame     <= 1'b1;
            count        <= next_count;
            frame_number <= next_count;
        end else if (frame_end && in_frame) begin
            in_frame <= 1'b0;
        end
        if (frame_limit == 16'h0000 && !in_frame) begin
            count <= 16'h0000;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// sync generator, sixteen-bit low period only; held off in separate mode
wire [15:0] low_period = {sync_low_period_high_byte, sync_low_period_low_byte};
reg  [15:0] period_count;

always @(posedge clk) begin
    if (!reset_n) begin
        sync_out     <= 1'b0;
        period_count <= 16'h0000;
    end else if (!sync_control[`SC_ENABLE_BIT] || sync_control[`SC_SEPARATE_BIT]) begin
        sync_out     <= 1'b0;
        period_count <= 16'h0000;
    end else if (!sync_out) begin
        // value+1 cycles low; high phase kept to one cycle here
        if (period_count >= low_period) begin
            sync_out     <= 1'b1;
            period_count <= 16'h0000;
        end else begin
            period_count <= period_count + 16'h0001;
        end
    end else begin
        sync_out <= 1'b0;
    end
end

endmodule

// file: hdl/video_forward_clock_config_regs.vh
`ifndef VIDEO_FORWARD_CLOCK_CONFIG_REGS_VH
`define VIDEO_FORWARD_CLOCK_CONFIG_REGS_VH

// register indices; byte address is four times the index
`define IDX_SYNC_LOW_PERIOD_LOW_BYTE  8'h1c
`define IDX_FRAME_COUNT_LIMIT_HIGH    8'h1d
`define IDX_FRAME_COUNT_LIMIT_LOW     8'h1e
`define IDX_OUTPUT_CLOCK_CONTROL      8'h1f
`define IDX_PORT_FORWARD_CONTROL      8'h20
`define IDX_SYNC_LOW_PERIOD_HIGH_BYTE 8'h1b
`define IDX_SYNC_CONTROL              8'h18

`define RST_SYNC_LOW_PERIOD_LOW_BYTE  8'h00
`define RST_SYNC_LOW_PERIOD_HIGH_BYTE 8'h00
`define RST_FRAME_COUNT_LIMIT_HIGH    8'h00
`define RST_FRAME_COUNT_LIMIT_LOW     8'h04
`define RST_OUTPUT_CLOCK_CONTROL      8'h02
`define RST_PORT_FORWARD_CONTROL      8'hf0
`define RST_SYNC_CONTROL              8'h00

// output clock control fields
`define OCC_OSC_SELECT_BIT   3
`define OCC_REF_MODE_BIT     2
`define OCC_SPEED_MSB        1
`define OCC_SPEED_LSB        0
`define OCC_WRITE_MASK       8'h0f
`define SPEED_400M           2'h3

// port forward control fields
`define PFC_OFF_LSB          4
`define PFC_SELECT_LSB       0

// sync control fields
`define SC_ENABLE_BIT        0
`define SC_SEPARATE_BIT      1

`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2

`endif

// file: verification/video_forward_clock_config_assertions.sv
`timescale 1ns/1ps
module video_forward_clock_config_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        frame_start,
    input wire logic [15:0] frame_number,
    input wire logic        sync_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // both halves are held one cycle before the answer is raised
    property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_done: assert property (p_b_done) else $error("bvalid held");
    property p_b_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_busy: assert property (p_b_busy) else $error("write taken early");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_done: assert property (p_r_done) else $error("rvalid held");
    property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_r_busy: assert property (p_r_busy) else $error("read taken early");
    // number only moves on a frame start, so start and end packets agree
    property p_frame_hold; !frame_start |=> $stable(frame_number); endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("frame number moved");
    property p_frame_step; frame_start |=> frame_number <= 16'h0001 || $stable(frame_number) || frame_number == $past(frame_number) + 16'h0001; endproperty
    a_frame_step: assert property (p_frame_step) else $error("frame number jump");
    property p_sync_pulse; $rose(sync_out) |=> !sync_out; endproperty
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync high too long");
endmodule
bind video_forward_clock_config video_forward_clock_config_checker u_chk (.clk(clk), .reset_n(reset_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .frame_start(frame_start), .frame_number(frame_number), .sync_out(sync_out));

// file: verification/video_forward_clock_config_tb.sv
`timescale 1ns/1ps
module video_forward_clock_config_tb;
    // answer readies stay high: no re-raise in the step that lowered them
    logic        clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 1;
    logic        arvalid = 0, rready = 1, raw_mode = 0, frame_start = 0, frame_end = 0;
    logic [9:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, got;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  resp;
    logic        ah, wh, bh;
    wire         awready, wready, bvalid, arready, rvalid, sync_out, osc, ref100;
    wire  [1:0]  bresp, rresp, tx_speed;
    wire  [31:0] rdata;
    wire  [15:0] frame_number;
    wire  [3:0]  fwd_off, out_sel;
    int          num_errors = 0, num_checks = 0, cycles = 0, n;
    logic [9:0]  addrs [7] = '{10'h070, 10'h074, 10'h078, 10'h07c, 10'h080, 10'h06c, 10'h060};
    logic [7:0]  rsts [7] = '{8'h00, 8'h00, 8'h04, 8'h02, 8'hf0, 8'h00, 8'h00};
    logic [7:0]  pats [4] = '{8'ha5, 8'h5a, 8'hf3, 8'h3c};
    video_forward_clock_config DUT (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .raw_mode(raw_mode), .frame_start(frame_start),
        .frame_end(frame_end), .frame_number(frame_number), .sync_out(sync_out),
        .internal_oscillator_select(osc), .ref_clock_100m(ref100), .tx_speed(tx_speed),
        .port_forward_off(fwd_off), .port_output_select(out_sel));
    initial forever #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // hang guard, far above the several hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            stop_test;
        end
    end
    task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // ready is sampled mid-cycle, released on the next rising edge
    task wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1;
        wvalid <= 1;
        do begin
            @(negedge clk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            resp = bresp;
            @(posedge clk);
            if (ah) awvalid <= 0;
            if (wh) wvalid <= 0;
        end while (!bh);
        chk("bresp", {30'h0, er}, {30'h0, resp});
    endtask
    task rd(input logic [9:0] a, input logic [7:0] exp, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1;
        do begin
            @(negedge clk);
            ah = arvalid && arready;
            bh = rvalid;
            got = rdata;
            resp = rresp;
            @(posedge clk);
            if (ah) arvalid <= 0;
        end while (!bh);
        chk("rdata", {24'h00_0000, exp}, got);
        chk("rresp", {30'h0, er}, {30'h0, resp});
    endtask
    task frame(input logic [15:0] exp);
        frame_start <= 1;
        @(posedge clk);
        frame_start <= 0;
        @(negedge clk);
        chk("frame_number start", {16'h0000, exp}, {16'h0000, frame_number});
        @(posedge clk);
        frame_end <= 1;
        @(posedge clk);
        frame_end <= 0;
        @(negedge clk);
        chk("frame_number end", {16'h0000, exp}, {16'h0000, frame_number});
        @(posedge clk);
    endtask
    task sync_low(input int exp);
        n = 0;
        while (sync_out !== 1'b1) @(negedge clk);
        @(negedge clk);
        while (sync_out === 1'b0) begin
            n++;
            @(negedge clk);
        end
        chk("sync low cycles", exp, n);
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1;
        @(posedge clk);
        chk("outputs", 32'h0000_02f0, {20'h0, osc, ref100, tx_speed, fwd_off, out_sel});
        for (int i = 0; i < 7; i++) rd(addrs[i], rsts[i], 2'h0);
        // speed codes 01, 10, 11, 00 in turn; 100 MHz never paired with 400 Mbps
        foreach (pats[j]) begin
            wr(10'h080, {4'hf, out_sel}, 2'h0);
            for (int i = 0; i < 5; i++) wr(addrs[i], pats[j], 2'h0);
            for (int i = 0; i < 5; i++) rd(addrs[i], (i == 3) ? pats[j] & 8'h0f : pats[j], 2'h0);
            chk("outputs", {20'h0, pats[j][3:0], pats[j]}, {20'h0, osc, ref100, tx_speed, fwd_off, out_sel});
        end
        wr(10'h100, 8'h55, 2'h2);
        rd(10'h100, 8'h00, 2'h2);
        wr(10'h074, 8'h00, 2'h0);
        wr(10'h078, 8'h02, 2'h0);
        raw_mode <= 1;
        frame(16'h0001);
        frame(16'h0002);
        frame(16'h0001);
        wr(10'h078, 8'h00, 2'h0);
        frame(16'h0000);
        wr(10'h06c, 8'h00, 2'h0);
        wr(10'h070, 8'h02, 2'h0);
        wr(10'h060, 8'h01, 2'h0);
        sync_low(3);
        wr(10'h06c, 8'h01, 2'h0);
        sync_low(259);
        stop_test;
    end
endmodule
